/* File: verif/dpmm_host_model.sv */
// Host-side bus model for the mailbox
`timescale 1ns/100ps
`default_nettype none
module dpmm_host_model (
	// Clock
	input wire logic clk,
	// Mailbox host bus
	output var dpmm_pkg::dpmm_host_t host,
	input wire logic [7:0] hostDataOut
);
	import dpmm_pkg::*;
	initial host = '1;
	task automatic acc(input logic w, cs, input logic [9:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		host.addrLow = a[7:0];
		host.addrHigh = a[9:8];
		// Released bus must not echo the last byte
		host.dataIn = w ? d : ~host.dataIn;
		host.csN = ~cs;
		host.wrN = ~w;
		host.rdN = w;
		repeat (3) @(negedge clk);
		q = hostDataOut;
		host = '1;
		@(negedge clk);
	endtask
endmodule // dpmm_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the dual-port mailbox
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import dpmm_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	dpmm_proc_t proc = '1;
	dpmm_host_t host;
	logic [7:0] pOut, hOut, q, obs, d;
	logic pOe, hOe, fullN, hsN, qOe;
	logic [9:0] a;
	logic [7:0] exps[$];
	int mismatches = 0;
	int n_compared = 0;
	event seen;
	always #2.5 clk = ~clk;
	dpmm_mailbox dpmm_mailbox_inst (.clk(clk), .rst(rst), .proc(proc),
		.procDataOut(pOut), .procDataOe(pOe), .host(host),
		.hostDataOut(hOut), .hostDataOe(hOe),
		.procToHostFullFlag_n(fullN), .hostToProcFlag_n(hsN));
	dpmm_host_model dpmm_host_model_inst (.clk(clk), .host(host),
		.hostDataOut(hOut));
	task automatic test_done;
		if (mismatches == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic note(input logic [7:0] g, e);
		exps.push_back(e);
		obs = g;
		->seen;
		#1;
	endtask
	task automatic check(input logic [7:0] g, e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	always @(seen) begin
		check(obs, exps[0]);
		void'(exps.pop_front());
	end
	task automatic pa(input logic w, input logic [2:0] s,
		input logic [9:0] ad, input logic [7:0] dd);
		@(negedge clk);
		proc = {s, 1'h0, ad, 1'h0, w, ~w, dd};
		repeat (3) @(negedge clk);
		q = pOut;
		qOe = pOe;
		proc.rdN = 1'h1;
		proc.wrN = 1'h1;
		@(negedge clk);
	endtask
	initial begin
		d = 8'($urandom(37));
		repeat (5) @(negedge clk);
		rst = 1'h0;
		repeat (3) @(negedge clk);
		pa(0, DPMM_SEL_FLAGS, 10'h0, 8'h0);
		note(q & 8'h03, 8'h03);
		note(qOe, 8'h0);
		for (int i = 0; i < 4; i++) begin
			a = 10'($urandom_range(10'h3fd));
			d = 8'($urandom);
			pa(1, DPMM_SEL_MEM, a, d);
			pa(1, 3'h3, a, ~d);
			dpmm_host_model_inst.acc(0, 1, a, 8'h0, q);
			note(q, d);
			dpmm_host_model_inst.acc(1, 1, a, ~d, q);
			dpmm_host_model_inst.acc(1, 0, a, d, q);
			pa(0, DPMM_SEL_MEM, a, 8'h0);
			note(q, ~d);
		end
		pa(1, DPMM_SEL_MEM, DPMM_ADDR_FULL, 8'h11);
		note(fullN, 8'h0);
		pa(0, DPMM_SEL_FLAGS, 10'h0, 8'h0);
		note(q[1:0], 8'h2);
		dpmm_host_model_inst.acc(0, 0, DPMM_ADDR_FULL, 8'h0, q);
		note(fullN, 8'h0);
		dpmm_host_model_inst.acc(0, 1, DPMM_ADDR_FULL, 8'h0, q);
		note(q, 8'h11);
		note(fullN, 8'h1);
		dpmm_host_model_inst.acc(1, 1, DPMM_ADDR_HS, 8'h22, q);
		note(hsN, 8'h0);
		pa(0, DPMM_SEL_FLAGS, 10'h0, 8'h0);
		note(q[1:0], 8'h1);
		pa(0, DPMM_SEL_MEM, DPMM_ADDR_HS, 8'h0);
		note(q, 8'h22);
		note(hsN, 8'h1);
		note(pOe, 8'h1);
		note(hOe, 8'h1);
		test_done;
	end
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
endmodule // testbench
`default_nettype wire

/* File: verilog/dpmm_mailbox.sv */
// Dual-port message mailbox with active-low handshake flags
`timescale 1ns/100ps
`default_nettype none
module dpmm_mailbox (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Processor side
	input wire dpmm_pkg::dpmm_proc_t proc,
	output logic [7:0] procDataOut,
	output logic procDataOe,
	// Host side
	input wire dpmm_pkg::dpmm_host_t host,
	output logic [7:0] hostDataOut,
	output logic hostDataOe,
	// Flags, active low
	output logic procToHostFullFlag_n,
	output logic hostToProcFlag_n
);
	import dpmm_pkg::*;

	logic [7:0] mem [DPMM_DEPTH];
	logic procRdQ, procWrQ, hostRdQ, hostWrQ;
	logic fullSet, hsSet;
	logic [9:0] hostAddr;
	logic memEn, flagEn;
	logic procRdFall, procWrFall, hostRdFall, hostWrFall;
	logic [7:0] flagByte;

	assign hostAddr = {host.addrHigh, host.addrLow};
	assign memEn = !proc.memSelN && proc.addr[13:11] == DPMM_SEL_MEM;
	assign flagEn = !proc.memSelN && proc.addr[13:11] == DPMM_SEL_FLAGS;
	assign procRdFall = procRdQ && !proc.rdN;
	assign procWrFall = procWrQ && !proc.wrN;
	// Strobes count only while select is low
	assign hostRdFall = hostRdQ && !host.rdN && !host.csN;
	assign hostWrFall = hostWrQ && !host.wrN && !host.csN;

	always_comb begin
		flagByte = 8'h00;
		flagByte[DPMM_FLAG_FULL_BIT] = !fullSet;
		flagByte[DPMM_FLAG_HS_BIT] = !hsSet;
	end

	// Strobe history for falling-edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			procRdQ <= 1'h1;
			procWrQ <= 1'h1;
			hostRdQ <= 1'h1;
			hostWrQ <= 1'h1;
		end else begin
			procRdQ <= proc.rdN;
			procWrQ <= proc.wrN;
			hostRdQ <= host.rdN;
			hostWrQ <= host.wrN;
		end
	end

	// Shared memory; no arbitration, host wins a same-cycle collision
	always_ff @(posedge clk) begin
		if (hostWrFall)
			mem[hostAddr] <= host.dataIn;
		else if (memEn && procWrFall)
			mem[proc.addr[9:0]] <= proc.dataIn;
	end

	// Full flag: set wins over a simultaneous clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fullSet <= DPMM_FLAG_RST;
		else if (memEn && procWrFall && proc.addr[9:0] == DPMM_ADDR_FULL)
			fullSet <= 1'h1;
		else if (hostRdFall && hostAddr == DPMM_ADDR_FULL)
			fullSet <= 1'h0;
	end

	// Handshake flag: set wins over a simultaneous clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			hsSet <= DPMM_FLAG_RST;
		else if (hostWrFall && hostAddr == DPMM_ADDR_HS)
			hsSet <= 1'h1;
		else if (memEn && procRdFall && proc.addr[9:0] == DPMM_ADDR_HS)
			hsSet <= 1'h0;
	end

	// Active-low flag pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			procToHostFullFlag_n <= 1'h1;
			hostToProcFlag_n <= 1'h1;
		end else begin
			procToHostFullFlag_n <= !fullSet;
			hostToProcFlag_n <= !hsSet;
		end
	end

	// Processor data bus: memory byte or flag buffer; enable low drives
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			procDataOut <= 8'h00;
			procDataOe <= 1'h1;
		end else if (!proc.rdN && flagEn) begin
			procDataOut <= flagByte;
			procDataOe <= 1'h0;
		end else if (!proc.rdN && memEn) begin
			procDataOut <= mem[proc.addr[9:0]];
			procDataOe <= 1'h0;
		end else begin
			procDataOe <= 1'h1;
		end
	end

	// Host data bus, driven only during a selected read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hostDataOut <= 8'h00;
			hostDataOe <= 1'h1;
		end else if (!host.rdN && !host.csN) begin
			hostDataOut <= mem[hostAddr];
			hostDataOe <= 1'h0;
		end else begin
			hostDataOe <= 1'h1;
		end
	end

	a_full_set: assert property (@(posedge clk) disable iff (rst)
		memEn && procWrFall && proc.addr[9:0] == DPMM_ADDR_FULL
		|=> ##1 !procToHostFullFlag_n)
		else $error("full flag not set by processor write");
	a_full_clear: assert property (@(posedge clk) disable iff (rst)
		hostRdFall && hostAddr == DPMM_ADDR_FULL &&
		!(memEn && procWrFall && proc.addr[9:0] == DPMM_ADDR_FULL)
		|=> ##1 procToHostFullFlag_n)
		else $error("full flag not cleared by host read");
	a_hs_set: assert property (@(posedge clk) disable iff (rst)
		hostWrFall && hostAddr == DPMM_ADDR_HS
		|=> ##1 !hostToProcFlag_n)
		else $error("handshake flag not set by host write");
	a_hs_clear: assert property (@(posedge clk) disable iff (rst)
		memEn && procRdFall && proc.addr[9:0] == DPMM_ADDR_HS &&
		!(hostWrFall && hostAddr == DPMM_ADDR_HS)
		|=> ##1 hostToProcFlag_n)
		else $error("handshake flag not cleared by processor read");
	a_flag_pins: assert property (@(posedge clk) disable iff (rst)
		procToHostFullFlag_n == !$past(fullSet) &&
		hostToProcFlag_n == !$past(hsSet))
		else $error("flag pins not inverse of flag state");
	a_flag_drive: assert property (@(posedge clk) disable iff (rst)
		!procDataOe |-> $past(!proc.rdN && (flagEn || memEn)))
		else $error("processor bus driven without decode");
	a_flag_bits: assert property (@(posedge clk) disable iff (rst)
		!proc.rdN && flagEn |=> !procDataOe &&
		procDataOut[1:0] == {!$past(hsSet), !$past(fullSet)})
		else $error("flag byte wrong on processor bus");
	// Only host accesses clear the full flag or set the handshake flag
	a_host_cs: assert property (@(posedge clk) disable iff (rst)
		host.csN |=> hostDataOe && !$fell(fullSet) && !$rose(hsSet))
		else $error("host access acted without select");
	a_proc_mem: assert property (@(posedge clk) disable iff (rst)
		!proc.rdN && memEn && !flagEn |=> !procDataOe)
		else $error("memory read not driven");

	c_full_cycle: cover property (@(posedge clk) disable iff (rst)
		!procToHostFullFlag_n ##[1:50] procToHostFullFlag_n);
	c_hs_cycle: cover property (@(posedge clk) disable iff (rst)
		!hostToProcFlag_n ##[1:50] hostToProcFlag_n);
	c_flag_read: cover property (@(posedge clk) disable iff (rst)
		!procDataOe && flagEn);
endmodule // dpmm_mailbox
`default_nettype wire

/* File: verilog/dpmm_pkg.sv */
// Package for the dual-port message mailbox: constants and carrier types
`default_nettype none
package dpmm_pkg;
	localparam int DPMM_AW = 10;
	localparam int DPMM_DEPTH = 1024;
	localparam logic [2:0] DPMM_SEL_MEM = 3'h2;
	localparam logic [2:0] DPMM_SEL_FLAGS = 3'h4;
	localparam logic [9:0] DPMM_ADDR_FULL = 10'h3ff;
	localparam logic [9:0] DPMM_ADDR_HS = 10'h3fe;
	localparam int DPMM_FLAG_FULL_BIT = 0;
	localparam int DPMM_FLAG_HS_BIT = 1;
	localparam logic DPMM_FLAG_RST = 1'h0;

	// Processor bus as seen by the mailbox
	typedef struct packed {
		logic [13:0] addr;
		logic memSelN;
		logic rdN;
		logic wrN;
		logic [7:0] dataIn;
	} dpmm_proc_t;

	// Host bus after the external address latch
	typedef struct packed {
		logic [7:0] addrLow;
		logic [1:0] addrHigh;
		logic csN;
		logic rdN;
		logic wrN;
		logic [7:0] dataIn;
	} dpmm_host_t;
endpackage
`default_nettype wire
